// *** fdcp_pkg.sv ***
// Shared constants for the floppy controller host port.
package fdcp_pkg;
    localparam logic [1:0] FDCP_SEL_STATUS  = 2'h0;
    localparam logic [1:0] FDCP_SEL_TRACK   = 2'h1;
    localparam logic [1:0] FDCP_SEL_SECTOR  = 2'h2;
    localparam logic [1:0] FDCP_SEL_DATA    = 2'h3;
    localparam logic [7:0] FDCP_CMD_RESET   = 8'h03;
    localparam logic [7:0] FDCP_SECT_RESET  = 8'h01;
    localparam logic [7:0] FDCP_TRACK_RESET = 8'h00;
    localparam logic [7:0] FDCP_DATA_RESET  = 8'h00;
    localparam logic [3:0] FDCP_OP_RESTORE  = 4'h0;
    localparam logic [3:0] FDCP_OP_XFER_MIN = 4'h8;
    localparam int         FDCP_ST_NREADY   = 7;
    localparam int         FDCP_ST_SEEKERR  = 4;
    localparam int         FDCP_ST_TRACK0   = 2;
    localparam int         FDCP_ST_XFER     = 1;
    localparam int         FDCP_ST_BUSY     = 0;
    localparam logic [7:0] FDCP_STEP_TICKS  = 8'h06;
    localparam logic [7:0] FDCP_STEP_LIMIT  = 8'hff;
    typedef enum logic [1:0] {
        FDCP_RS_IDLE  = 2'b00,
        FDCP_RS_CHECK = 2'b01,
        FDCP_RS_STEP  = 2'b10,
        FDCP_RS_WAIT  = 2'b11
    } fdcp_rs_state_t;
endpackage : fdcp_pkg

// *** fdcp_acc_if.sv ***
// Synchronised host access events passed from the strobe stage to the core.
`timescale 1ns/1ps
interface fdcp_acc_if;
    logic       rd_level;
    logic       rd_pulse;
    logic       wr_pulse;
    logic [1:0] sel;
    logic [7:0] wdata;
    modport sync (output rd_level, rd_pulse, wr_pulse, sel, wdata);
    modport core (input rd_level, rd_pulse, wr_pulse, sel, wdata);
endinterface : fdcp_acc_if

// *** fdcp_strobe_sync.sv ***
// Synchroniser and edge detector for the host strobes, select and data.
`timescale 1ns/1ps
module fdcp_strobe_sync
    import fdcp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [1:0] sel,
    input  wire logic [7:0] din,
    fdcp_acc_if.sync        acc
);
    logic [12:0] meta;
    logic [12:0] stable;
    logic        rd_prev;
    logic        wr_prev;
    logic        wr_level;

    // Data and select pass the same two stages, so they line up with strobes.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta   <= 13'h1fff;
            stable <= 13'h1fff;
        end else begin
            meta   <= {cs_n, rd_n, wr_n, sel, din};
            stable <= meta;
        end
    end

    // A write strobe wins if the host ever lowers both strobes.
    assign acc.rd_level = !stable[12] && !stable[11] && stable[10]; // RL5
    assign wr_level     = !stable[12] && !stable[10]; // RL5
    assign acc.rd_pulse = acc.rd_level && !rd_prev; // RL13
    assign acc.wr_pulse = wr_level && !wr_prev; // RL13
    assign acc.sel      = stable[9:8];
    assign acc.wdata    = stable[7:0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_prev <= 1'b0;
            wr_prev <= 1'b0;
        end else begin
            rd_prev <= acc.rd_level;
            wr_prev <= wr_level;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_single_write: assert property (acc.wr_pulse |=> !acc.wr_pulse[*2]) // RL13
        else $error("Write strobe gave more than one access.");
    chk_deselect_quiet: assert property (stable[12] |-> // RL5
        !acc.rd_level && !acc.wr_pulse)
        else $error("Access seen while the chip was not selected.");
endmodule : fdcp_strobe_sync

// *** fdcp_restore.sv ***
// Seek-to-track-zero sequencer paced by the timing clock ticks.
`timescale 1ns/1ps
module fdcp_restore
    import fdcp_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic abort,
    input  wire logic start,
    input  wire logic tick,
    input  wire logic at_track0,
    output logic      busy,
    output logic      step,
    output logic      done,
    output logic      fail
);
    fdcp_rs_state_t state;
    logic [7:0]     wait_cnt;
    logic [7:0]     step_cnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= FDCP_RS_IDLE;
            wait_cnt <= 8'h00;
            step_cnt <= 8'h00;
            step     <= 1'b0;
            done     <= 1'b0;
            fail     <= 1'b0;
        end else if (abort) begin
            state <= FDCP_RS_IDLE;
            step  <= 1'b0;
            done  <= 1'b0;
        end else begin
            step <= 1'b0;
            done <= 1'b0;
            case (state)
                FDCP_RS_IDLE: begin
                    if (start) begin
                        state    <= FDCP_RS_CHECK;
                        step_cnt <= 8'h00;
                        fail     <= 1'b0;
                    end
                end
                FDCP_RS_CHECK: begin
                    if (at_track0) begin
                        state <= FDCP_RS_IDLE;
                        done  <= 1'b1;
                    end else if (step_cnt == FDCP_STEP_LIMIT) begin
                        // Give up rather than hang on a drive with no sensor.
                        state <= FDCP_RS_IDLE;
                        done  <= 1'b1;
                        fail  <= 1'b1;
                    end else begin
                        state <= FDCP_RS_STEP;
                    end
                end
                FDCP_RS_STEP: begin
                    step     <= 1'b1;
                    step_cnt <= step_cnt + 8'h01;
                    wait_cnt <= FDCP_STEP_TICKS;
                    state    <= FDCP_RS_WAIT;
                end
                FDCP_RS_WAIT: begin
                    if (wait_cnt == 8'h00) begin
                        state <= FDCP_RS_CHECK;
                    end else if (tick) begin
                        wait_cnt <= wait_cnt - 8'h01;
                    end
                end
                default: state <= FDCP_RS_IDLE;
            endcase
        end
    end

    assign busy = (state != FDCP_RS_IDLE);
endmodule : fdcp_restore

// *** fdcp_host_port.sv ***
// Host register port, master reset handling and restore launch.
`timescale 1ns/1ps
// Summary of operation
// RL1: Master reset low resets state and loads command register with 03; the code keeps the seek error bit (rs_fail) through it.
// RL2: Not-ready status bit 7 reads cleared while master reset is low.
// RL3: Releasing master reset launches a restore whatever the ready input.
// RL4: Master reset loads the sector register with 01.
// RL5: Strobes are ignored unless chip select is low.
// RL6: Select and write strobe low capture bus data into the chosen register.
// RL7: Select and read strobe low drive the chosen register, else bus released.
// RL8: Code 0 status/command, 1 track, 2 sector, 3 data register.
// RL9: Data bus is inverted; writes receive, reads transmit.
// RL10: The system supplies a free-running 2 MHz or 1 MHz timing clock.
// RL11: Interrupt rises on command completion, clears on status read or command.
// RL12: Transfer request is cleared when the host reads or loads data.
// RL13: Strobes are synchronised; each strobe gives exactly one access.
module fdcp_host_port
    import fdcp_pkg::*;
(
    input  wire logic       CLK_SYS,
    input  wire logic       RST_N,
    input  wire logic       MASTER_RESET_N,
    input  wire logic       CHIP_SEL_N,
    input  wire logic       REG_READ_STROBE_N,
    input  wire logic       REG_WRITE_STROBE_N,
    input  wire logic [1:0] REG_SEL,
    input  wire logic [7:0] HOST_DATA_BUS_IN,
    output logic      [7:0] HOST_DATA_BUS_OUT,
    output logic            HOST_DATA_BUS_OE_N,
    input  wire logic       TIMING_CLK,
    input  wire logic       DRIVE_READY,
    input  wire logic       TRACK_ZERO_N,
    output logic            STEP_OUT,
    output logic            IRQ_OUT,
    output logic            XFER_REQUEST_OUT
);
    fdcp_acc_if acc ();

    logic [2:0] mr_sync;
    logic [2:0] tclk_sync;
    logic [1:0] rdy_sync;
    logic [1:0] tr0_sync;
    logic       mr_active;
    logic       mr_release;
    logic       tick;
    logic [7:0] command_entry;
    logic [7:0] current_track;
    logic [7:0] target_sector;
    logic [7:0] transfer_byte;
    logic [7:0] drive_status;
    logic       xfer_busy;
    logic       rs_busy;
    logic       rs_step;
    logic       rs_done;
    logic       rs_fail;
    logic       cmd_write;
    logic       restore_go;
    logic       data_touch;
    logic       xfer_done;
    logic       cmd_done;
    logic [7:0] next_dout;

    function automatic logic [7:0] fdcp_pick(
        input logic [1:0] sel,
        input logic [7:0] st,
        input logic [7:0] trk,
        input logic [7:0] sec,
        input logic [7:0] dat
    );
        case (sel)
            FDCP_SEL_STATUS: fdcp_pick = st;
            FDCP_SEL_TRACK:  fdcp_pick = trk;
            FDCP_SEL_SECTOR: fdcp_pick = sec;
            default:         fdcp_pick = dat;
        endcase
    endfunction : fdcp_pick

    fdcp_strobe_sync u_sync (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .cs_n  (CHIP_SEL_N),
        .rd_n  (REG_READ_STROBE_N),
        .wr_n  (REG_WRITE_STROBE_N),
        .sel   (REG_SEL),
        .din   (HOST_DATA_BUS_IN),
        .acc   (acc.sync)
    );

    // Pins from outside the clock domain pass two flip-flops first.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            mr_sync   <= 3'h0;
            tclk_sync <= 3'h0;
            rdy_sync  <= 2'h0;
            tr0_sync  <= 2'h3;
        end else begin
            mr_sync   <= {mr_sync[1:0], MASTER_RESET_N};
            tclk_sync <= {tclk_sync[1:0], TIMING_CLK};
            rdy_sync  <= {rdy_sync[0], DRIVE_READY};
            tr0_sync  <= {tr0_sync[0], TRACK_ZERO_N};
        end
    end

    // The timing clock is far slower than the system clock, so an edge
    // detect on it gives a clean one-cycle enable.
    assign mr_active  = !mr_sync[1];
    assign mr_release = mr_sync[1] && !mr_sync[2]; // RL3
    assign tick       = tclk_sync[1] && !tclk_sync[2]; // RL10

    assign cmd_write  = acc.wr_pulse && (acc.sel == FDCP_SEL_STATUS); // RL8
    assign restore_go = mr_release || (cmd_write && !rs_busy && !xfer_busy &&
                        (~acc.wdata[7:4] == FDCP_OP_RESTORE)); // RL3
    assign data_touch = (acc.wr_pulse || acc.rd_pulse) &&
                        (acc.sel == FDCP_SEL_DATA);
    assign xfer_done  = xfer_busy && data_touch;
    assign cmd_done   = rs_done || xfer_done;

    fdcp_restore u_restore (
        .clk       (CLK_SYS),
        .rst_n     (RST_N),
        .abort     (mr_active),
        .start     (restore_go),
        .tick      (tick),
        .at_track0 (!tr0_sync[1]),
        .busy      (rs_busy),
        .step      (rs_step),
        .done      (rs_done),
        .fail      (rs_fail)
    );

    // Not ready is forced clear while master reset is held.
    always_comb begin
        drive_status                  = 8'h00;
        drive_status[FDCP_ST_NREADY]  = !rdy_sync[1] && !mr_active; // RL2
        drive_status[FDCP_ST_SEEKERR] = rs_fail;
        drive_status[FDCP_ST_TRACK0]  = !tr0_sync[1];
        drive_status[FDCP_ST_XFER]    = XFER_REQUEST_OUT;
        drive_status[FDCP_ST_BUSY]    = rs_busy || xfer_busy;
    end

    // Command register; incoming bus data is inverted back to true form.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            command_entry <= FDCP_CMD_RESET;
        end else if (mr_active) begin
            command_entry <= FDCP_CMD_RESET; // RL1
        end else if (cmd_write) begin
            command_entry <= ~acc.wdata; // RL6 RL9
        end
    end

    // Successful restore completion clears the track, winning over a host write.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            current_track <= FDCP_TRACK_RESET;
        end else if (mr_active) begin
            current_track <= FDCP_TRACK_RESET; // RL1
        end else if (rs_done && !rs_fail) begin
            current_track <= FDCP_TRACK_RESET;
        end else if (acc.wr_pulse && acc.sel == FDCP_SEL_TRACK) begin
            current_track <= ~acc.wdata; // RL6 RL8
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            target_sector <= FDCP_SECT_RESET;
        end else if (mr_active) begin
            target_sector <= FDCP_SECT_RESET; // RL4
        end else if (acc.wr_pulse && acc.sel == FDCP_SEL_SECTOR) begin
            target_sector <= ~acc.wdata; // RL6 RL8
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            transfer_byte <= FDCP_DATA_RESET;
        end else if (mr_active) begin
            transfer_byte <= FDCP_DATA_RESET; // RL1
        end else if (acc.wr_pulse && acc.sel == FDCP_SEL_DATA) begin
            transfer_byte <= ~acc.wdata; // RL6 RL8
        end
    end

    // A transfer command holds one byte exchange through the data register.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            xfer_busy        <= 1'b0;
            XFER_REQUEST_OUT <= 1'b0;
        end else if (mr_active) begin
            xfer_busy        <= 1'b0;
            XFER_REQUEST_OUT <= 1'b0;
        end else if (cmd_write && !rs_busy && !xfer_busy &&
                     (~acc.wdata[7:4] >= FDCP_OP_XFER_MIN)) begin
            xfer_busy        <= 1'b1;
            XFER_REQUEST_OUT <= 1'b1;
        end else if (data_touch) begin
            xfer_busy        <= 1'b0;
            XFER_REQUEST_OUT <= 1'b0; // RL12
        end
    end

    // Completion sets the interrupt even in the cycle the host clears it.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            IRQ_OUT <= 1'b0;
        end else if (mr_active) begin
            IRQ_OUT <= 1'b0;
        end else if (cmd_done) begin
            IRQ_OUT <= 1'b1; // RL11
        end else if (cmd_write ||
                     (acc.rd_pulse && acc.sel == FDCP_SEL_STATUS)) begin
            IRQ_OUT <= 1'b0; // RL11
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            STEP_OUT <= 1'b0;
        end else begin
            STEP_OUT <= rs_step;
        end
    end

    assign next_dout = ~fdcp_pick(acc.sel, drive_status, current_track,
                                  target_sector, transfer_byte); // RL8 RL9

    // The bus is driven only while selected and read-strobed.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            HOST_DATA_BUS_OUT  <= 8'hff;
            HOST_DATA_BUS_OE_N <= 1'b1;
        end else begin
            HOST_DATA_BUS_OUT  <= acc.rd_level ? next_dout : 8'hff; // RL7
            HOST_DATA_BUS_OE_N <= !acc.rd_level; // RL7
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    chk_mr_command: assert property (mr_active |=> // RL1
        command_entry == FDCP_CMD_RESET && IRQ_OUT == 1'b0)
        else $error("Command register not preset during master reset.");
    chk_mr_notready: assert property (mr_active |-> // RL2
        !drive_status[FDCP_ST_NREADY])
        else $error("Not ready bit set during master reset.");
    chk_mr_restore: assert property (mr_release |=> rs_busy) // RL3
        else $error("Restore not launched after master reset.");
    chk_mr_sector: assert property (mr_active ##1 !mr_active |-> // RL4
        target_sector == FDCP_SECT_RESET)
        else $error("Sector register not preset by master reset.");
    chk_write_track: assert property (acc.wr_pulse && !mr_active && // RL6
        !rs_done && acc.sel == FDCP_SEL_TRACK |=>
        current_track == ~$past(acc.wdata))
        else $error("Track write did not store inverted bus data.");
    chk_read_drive: assert property (acc.rd_level |=> // RL7
        !HOST_DATA_BUS_OE_N && HOST_DATA_BUS_OUT == $past(next_dout))
        else $error("Selected register not driven during a read.");
    chk_bus_release: assert property (!acc.rd_level |=> // RL7
        HOST_DATA_BUS_OE_N)
        else $error("Bus driven outside a read access.");
    chk_status_code: assert property (acc.rd_level && // RL8
        acc.sel == FDCP_SEL_STATUS |=>
        HOST_DATA_BUS_OUT == ~$past(drive_status))
        else $error("Code zero read did not return the status.");
    chk_irq_clear: assert property (!mr_active && !cmd_done && // RL11
        acc.rd_pulse && acc.sel == FDCP_SEL_STATUS |=> !IRQ_OUT)
        else $error("Status read did not clear the interrupt.");
    chk_irq_set: assert property (!mr_active && cmd_done |=> IRQ_OUT) // RL11
        else $error("Command completion did not raise the interrupt.");
    chk_drq_clear: assert property (!mr_active && data_touch && // RL12
        !cmd_write |=> !XFER_REQUEST_OUT)
        else $error("Data access did not clear the transfer request.");

    // Write checks leave out master reset cycles, where the presets win.
    chk_drq_set: assert property (!mr_active && cmd_write && // RL12
        !rs_busy && !xfer_busy &&
        ~acc.wdata[7:4] >= FDCP_OP_XFER_MIN |=> XFER_REQUEST_OUT)
        else $error("Transfer command did not raise the data request.");
    chk_irq_command: assert property (!mr_active && !cmd_done && // RL11
        cmd_write |=> !IRQ_OUT)
        else $error("Command write did not clear the interrupt.");
    chk_write_command: assert property (cmd_write && !mr_active |=> // RL6
        command_entry == ~$past(acc.wdata))
        else $error("Command write did not store inverted bus data.");
    chk_write_sector: assert property (acc.wr_pulse && !mr_active && // RL6
        acc.sel == FDCP_SEL_SECTOR |=> target_sector == ~$past(acc.wdata))
        else $error("Sector write did not store inverted bus data.");
    chk_write_data: assert property (acc.wr_pulse && !mr_active && // RL6
        acc.sel == FDCP_SEL_DATA |=> transfer_byte == ~$past(acc.wdata))
        else $error("Data write did not store inverted bus data.");
    chk_mr_track: assert property (mr_active |=> // RL1
        current_track == FDCP_TRACK_RESET && transfer_byte == FDCP_DATA_RESET)
        else $error("Track or data register not cleared by master reset.");
    chk_mr_outputs: assert property (mr_active |=> // RL1
        !XFER_REQUEST_OUT && !rs_busy && !xfer_busy)
        else $error("Master reset did not clear the port state.");
    chk_step_pulse: assert property (STEP_OUT |=> !STEP_OUT) // RL3
        else $error("Step pulse lasted more than one cycle.");
endmodule : fdcp_host_port

// *** fdcp_host_model.sv ***
// Host processor model that drives the register port pins.
`timescale 1ns/1ps
module fdcp_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] bus_out,
    input  wire logic       bus_oe_n,
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic      [1:0] sel,
    output logic      [7:0] bus_in,
    output logic            timing_clk
);
    logic       drv_en;
    logic [7:0] drv_val;
    logic [7:0] idle_pat;

    initial begin
        cs_n       = 1'b1;
        rd_n       = 1'b1;
        wr_n       = 1'b1;
        sel        = 2'h0;
        drv_en     = 1'b0;
        drv_val    = 8'h00;
    end

    // Free-running 2 MHz timing clock, never stopped between accesses.
    initial begin
        timing_clk = 1'b0;
        forever #250 timing_clk = ~timing_clk;
    end

    // A released bus keeps changing so a stale value can never match.
    always @(posedge clk) idle_pat <= (idle_pat === 8'h5a) ? 8'ha5 : 8'h5a;

    // Wire level: host write data, else device read data, else floating.
    assign bus_in = drv_en ? drv_val : (!bus_oe_n ? bus_out : idle_pat);

    // Write cycle; the strobe is held well past the synchroniser delay.
    task automatic wr_reg(input logic [1:0] s, input logic [7:0] v,
                          input logic csn);
        @(negedge clk);
        cs_n    = csn;
        sel     = s;
        drv_val = ~v;
        drv_en  = 1'b1;
        wr_n    = 1'b0;
        repeat (4) @(negedge clk);
        wr_n = 1'b1;
        cs_n = 1'b1;
        @(negedge clk);
        drv_en = 1'b0;
        repeat (3) @(negedge clk);
    endtask : wr_reg

    // Read cycle; data is taken while the strobe is still low.
    task automatic rd_reg(input logic [1:0] s, input logic csn,
                          output logic [7:0] v, output logic oe_n);
        @(negedge clk);
        cs_n = csn;
        sel  = s;
        rd_n = 1'b0;
        repeat (4) @(negedge clk);
        v    = ~bus_out;
        oe_n = bus_oe_n;
        rd_n = 1'b1;
        cs_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask : rd_reg
endmodule : fdcp_host_model

// *** tb.sv ***
// Self-checking testbench for the floppy controller host port.
`timescale 1ns/1ps
module tb;
    import fdcp_pkg::*;

    logic       CLK_SYS;
    logic       RST_N;
    logic       MASTER_RESET_N;
    logic       CHIP_SEL_N;
    logic       REG_READ_STROBE_N;
    logic       REG_WRITE_STROBE_N;
    logic [1:0] REG_SEL;
    logic [7:0] HOST_DATA_BUS_IN;
    logic [7:0] HOST_DATA_BUS_OUT;
    logic       HOST_DATA_BUS_OE_N;
    logic       TIMING_CLK;
    logic       DRIVE_READY;
    logic       TRACK_ZERO_N;
    logic       STEP_OUT;
    logic       IRQ_OUT;
    logic       XFER_REQUEST_OUT;
    int         error_cnt;
    int         checks;
    logic [7:0] rv;
    logic       oe;

    fdcp_host_port dut (
        .CLK_SYS(CLK_SYS), .RST_N(RST_N), .MASTER_RESET_N(MASTER_RESET_N),
        .CHIP_SEL_N(CHIP_SEL_N), .REG_READ_STROBE_N(REG_READ_STROBE_N),
        .REG_WRITE_STROBE_N(REG_WRITE_STROBE_N), .REG_SEL(REG_SEL),
        .HOST_DATA_BUS_IN(HOST_DATA_BUS_IN),
        .HOST_DATA_BUS_OUT(HOST_DATA_BUS_OUT),
        .HOST_DATA_BUS_OE_N(HOST_DATA_BUS_OE_N), .TIMING_CLK(TIMING_CLK),
        .DRIVE_READY(DRIVE_READY), .TRACK_ZERO_N(TRACK_ZERO_N),
        .STEP_OUT(STEP_OUT), .IRQ_OUT(IRQ_OUT),
        .XFER_REQUEST_OUT(XFER_REQUEST_OUT)
    );

    fdcp_host_model host (
        .clk(CLK_SYS), .bus_out(HOST_DATA_BUS_OUT),
        .bus_oe_n(HOST_DATA_BUS_OE_N), .cs_n(CHIP_SEL_N),
        .rd_n(REG_READ_STROBE_N), .wr_n(REG_WRITE_STROBE_N),
        .sel(REG_SEL), .bus_in(HOST_DATA_BUS_IN), .timing_clk(TIMING_CLK)
    );

    initial begin
        CLK_SYS = 1'b0;
        forever #20 CLK_SYS = ~CLK_SYS;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk

    task automatic final_report;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    // Master reset presets, then the restore that its release launches.
    task automatic t_master_reset;
        int n;
        host.rd_reg(FDCP_SEL_STATUS, 1'b0, rv, oe);
        chk({7'h0, rv[FDCP_ST_NREADY]}, 8'h00);
        host.wr_reg(FDCP_SEL_TRACK, 8'h55, 1'b0);
        host.rd_reg(FDCP_SEL_TRACK, 1'b0, rv, oe);
        chk(rv, 8'h00);
        host.rd_reg(FDCP_SEL_SECTOR, 1'b0, rv, oe);
        chk(rv, 8'h01);
        @(negedge CLK_SYS);
        MASTER_RESET_N = 1'b1;
        n = 0;
        while (STEP_OUT !== 1'b1 && n < 200) begin
            @(negedge CLK_SYS);
            n++;
        end
        chk({7'h0, STEP_OUT}, 8'h01);
        host.rd_reg(FDCP_SEL_STATUS, 1'b0, rv, oe);
        chk(rv & 8'h81, 8'h81);
        TRACK_ZERO_N = 1'b0;
        n = 0;
        while (IRQ_OUT !== 1'b1 && n < 400) begin
            @(negedge CLK_SYS);
            n++;
        end
        chk({7'h0, IRQ_OUT}, 8'h01);
        host.rd_reg(FDCP_SEL_STATUS, 1'b0, rv, oe);
        chk(rv & 8'h85, 8'h84);
        chk({7'h0, IRQ_OUT}, 8'h00);
        host.rd_reg(FDCP_SEL_SECTOR, 1'b0, rv, oe);
        chk(rv, 8'h01);
    endtask : t_master_reset

    // Track, sector and data slots written with their own values, then read back.
    task automatic t_decode;
        logic [7:0] vals [3];
        vals = '{8'h3c, 8'ha5, 8'h96};
        DRIVE_READY = 1'b1;
        for (int i = 0; i < 3; i++) begin
            host.wr_reg(2'(i + 1), vals[i], 1'b0);
        end
        for (int i = 0; i < 3; i++) begin
            host.rd_reg(2'(i + 1), 1'b0, rv, oe);
            chk(rv, vals[i]);
            chk({7'h0, oe}, 8'h00);
        end
        chk({7'h0, HOST_DATA_BUS_OE_N}, 8'h01);
        host.rd_reg(FDCP_SEL_STATUS, 1'b0, rv, oe);
        chk(rv, 8'h04);
    endtask : t_decode

    // Strobes with the chip deselected leave state and bus alone.
    task automatic t_cs_ignored;
        host.wr_reg(FDCP_SEL_TRACK, 8'h11, 1'b1);
        host.rd_reg(FDCP_SEL_TRACK, 1'b1, rv, oe);
        chk({7'h0, oe}, 8'h01);
        host.rd_reg(FDCP_SEL_TRACK, 1'b0, rv, oe);
        chk(rv, 8'h3c);
    endtask : t_cs_ignored

    // Transfer command raises the data request; the data read serves it.
    task automatic t_transfer;
        host.wr_reg(FDCP_SEL_STATUS, 8'h80, 1'b0);
        chk({7'h0, XFER_REQUEST_OUT}, 8'h01);
        host.rd_reg(FDCP_SEL_DATA, 1'b0, rv, oe);
        chk({7'h0, XFER_REQUEST_OUT}, 8'h00);
        chk({7'h0, IRQ_OUT}, 8'h01);
        host.wr_reg(FDCP_SEL_STATUS, 8'h10, 1'b0);
        chk({7'h0, IRQ_OUT}, 8'h00);
        host.wr_reg(FDCP_SEL_STATUS, 8'h00, 1'b0);
        chk({7'h0, IRQ_OUT}, 8'h01);
        host.rd_reg(FDCP_SEL_TRACK, 1'b0, rv, oe);
        chk(rv, 8'h00);
    endtask : t_transfer

    // The whole run needs a few hundred cycles; this bounds a hang.
    initial begin
        repeat (20000) @(posedge CLK_SYS);
        error_cnt++;
        final_report();
    end

    initial begin
        error_cnt      = 0;
        checks         = 0;
        RST_N          = 1'b0;
        MASTER_RESET_N = 1'b0;
        DRIVE_READY    = 1'b0;
        TRACK_ZERO_N   = 1'b1;
        repeat (12) @(negedge CLK_SYS);
        RST_N = 1'b1;
        repeat (4) @(negedge CLK_SYS);
        t_master_reset();
        t_decode();
        t_cs_ignored();
        t_transfer();
        final_report();
    end
endmodule : tb
